// *** hw/qps_top.v ***
// questionable status group with its power sub-group and status-byte summary
// assumes hardware status levels arrive asynchronously; commands are on sys_clk
`include "qps_defines.vh"

module qps_top #(
   parameter WIDTH = `QPS_WORD_W
) (
   // clock and control
   input wire sys_clk,
   input wire reset,
   input wire clk_en,
   // hardware status, asynchronous levels
   input wire guard_trip,
   input wire unleveled,
   input wire iq_overdrive,
   input wire heater_fault,
   input wire freq_summary,
   // guard clear command pulse
   input wire guard_clear,
   // other questionable condition bits, asynchronous
   input wire [WIDTH-1:0] ques_other_cond,
   // command port
   input wire cmd_wr,
   input wire cmd_rd,
   input wire [`QPS_SEL_W-1:0] cmd_sel,
   input wire [WIDTH-1:0] cmd_wdata,
   // answer
   output reg [WIDTH-1:0] cmd_rdata,
   output reg cmd_rvalid,
   // summaries
   output reg status_byte_ques,
   output reg guard_tripped
);

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   // two flops per async pin; only the second stage feeds any logic
   reg [4:0] sync_a;
   reg [4:0] sync_b;
   reg [WIDTH-1:0] other_a;
   reg [WIDTH-1:0] other_b;

   always @(posedge sys_clk) begin
      if (reset) begin
         sync_a <= 5'h00;
         sync_b <= 5'h00;
         other_a <= {WIDTH{1'b0}};
         other_b <= {WIDTH{1'b0}};
      end else if (clk_en) begin
         sync_a <= {freq_summary, heater_fault, iq_overdrive, unleveled, guard_trip};
         sync_b <= sync_a;
         other_a <= ques_other_cond;
         other_b <= other_a;
      end
   end

   // ----------------------------------------
   // reverse-power guard latch
   // ----------------------------------------
   // a trip still present in the clear cycle wins, the bit stays set
   always @(posedge sys_clk) begin
      if (reset) begin
         guard_tripped <= 1'b0;
      end else if (clk_en) begin
         if (sync_b[0]) begin
            guard_tripped <= 1'b1;
         end else if (guard_clear) begin
            guard_tripped <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // power condition word
   // ----------------------------------------
   reg [WIDTH-1:0] pwr_live;

   always @* begin
      pwr_live = {WIDTH{1'b0}};
      pwr_live[`QPS_PWR_GUARD_BIT] = guard_tripped;
      pwr_live[`QPS_PWR_UNLEVEL_BIT] = sync_b[1];
      pwr_live[`QPS_PWR_IQ_OVER_BIT] = sync_b[2];
      pwr_live[`QPS_PWR_HEATER_BIT] = sync_b[3];
   end

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   // condition and event selects decode to no write, so writes there are ignored
   wire wr_q_rise = cmd_wr && (cmd_sel == `QPS_SEL_Q_RISE);
   wire wr_q_fall = cmd_wr && (cmd_sel == `QPS_SEL_Q_FALL);
   wire wr_q_en = cmd_wr && (cmd_sel == `QPS_SEL_Q_ENABLE);
   wire wr_p_rise = cmd_wr && (cmd_sel == `QPS_SEL_P_RISE);
   wire wr_p_fall = cmd_wr && (cmd_sel == `QPS_SEL_P_FALL);
   wire wr_p_en = cmd_wr && (cmd_sel == `QPS_SEL_P_ENABLE);
   wire rd_q_event = cmd_rd && (cmd_sel == `QPS_SEL_Q_EVENT);
   wire rd_p_event = cmd_rd && (cmd_sel == `QPS_SEL_P_EVENT);

   // ----------------------------------------
   // power group
   // ----------------------------------------
   // condition register sits one edge behind the synchroniser, except the guard bit, which sits one edge behind its latch
   wire [WIDTH-1:0] p_cond;
   wire [WIDTH-1:0] p_rise;
   wire [WIDTH-1:0] p_fall;
   wire [WIDTH-1:0] p_event;
   wire [WIDTH-1:0] p_enable;
   wire p_summary;

   qps_group #(.WIDTH(WIDTH)) u_power (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .cond_in(pwr_live),
      .rise_wr(wr_p_rise),
      .fall_wr(wr_p_fall),
      .enable_wr(wr_p_en),
      .wr_data(cmd_wdata),
      .event_rd(rd_p_event),
      .cond(p_cond),
      .rise_filter(p_rise),
      .fall_filter(p_fall),
      .event_bits(p_event),
      .enable_mask(p_enable),
      .summary(p_summary)
   );

   // ----------------------------------------
   // questionable group
   // ----------------------------------------
   reg [WIDTH-1:0] ques_live;

   always @* begin
      ques_live = other_b;
      ques_live[`QPS_QUES_PWR_BIT] = p_summary;
      ques_live[`QPS_QUES_FREQ_BIT] = sync_b[4];
   end

   wire [WIDTH-1:0] q_cond;
   wire [WIDTH-1:0] q_rise;
   wire [WIDTH-1:0] q_fall;
   wire [WIDTH-1:0] q_event;
   wire [WIDTH-1:0] q_enable;
   wire q_summary;

   qps_group #(.WIDTH(WIDTH)) u_ques (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .cond_in(ques_live),
      .rise_wr(wr_q_rise),
      .fall_wr(wr_q_fall),
      .enable_wr(wr_q_en),
      .wr_data(cmd_wdata),
      .event_rd(rd_q_event),
      .cond(q_cond),
      .rise_filter(q_rise),
      .fall_filter(q_fall),
      .event_bits(q_event),
      .enable_mask(q_enable),
      .summary(q_summary)
   );

   // ----------------------------------------
   // read mux and registered outputs
   // ----------------------------------------
   reg [WIDTH-1:0] next_rdata;

   // unmapped selects read as zero
   always @* begin
      case (cmd_sel)
         `QPS_SEL_Q_COND: next_rdata = q_cond;
         `QPS_SEL_Q_EVENT: next_rdata = q_event;
         `QPS_SEL_Q_RISE: next_rdata = q_rise;
         `QPS_SEL_Q_FALL: next_rdata = q_fall;
         `QPS_SEL_Q_ENABLE: next_rdata = q_enable;
         `QPS_SEL_P_COND: next_rdata = p_cond;
         `QPS_SEL_P_EVENT: next_rdata = p_event;
         `QPS_SEL_P_RISE: next_rdata = p_rise;
         `QPS_SEL_P_FALL: next_rdata = p_fall;
         `QPS_SEL_P_ENABLE: next_rdata = p_enable;
         default: next_rdata = {WIDTH{1'b0}};
      endcase
   end

   always @(posedge sys_clk) begin
      if (reset) begin
         cmd_rdata <= {WIDTH{1'b0}};
         cmd_rvalid <= 1'b0;
         status_byte_ques <= 1'b0;
      end else if (clk_en) begin
         cmd_rvalid <= cmd_rd;
         if (cmd_rd) begin
            cmd_rdata <= next_rdata;
         end
         // registered so the status byte bit comes straight from a flop
         status_byte_ques <= q_summary;
      end
   end

endmodule

// *** hw/qps_defines.vh ***
// constants for the questionable / power status-reporting block
// assumes inclusion by qps_top.v and qps_group.v only
`ifndef QPS_DEFINES_VH
`define QPS_DEFINES_VH

// ----------------------------------------
// word layout
// ----------------------------------------
`define QPS_WORD_W 16
`define QPS_PWR_USED_MASK 16'h000f
`define QPS_QUES_PWR_BIT 3
`define QPS_QUES_FREQ_BIT 5
`define QPS_PWR_GUARD_BIT 0
`define QPS_PWR_UNLEVEL_BIT 1
`define QPS_PWR_IQ_OVER_BIT 2
`define QPS_PWR_HEATER_BIT 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define QPS_RISE_RESET 16'hffff
`define QPS_FALL_RESET 16'h0000
`define QPS_EVENT_RESET 16'h0000
`define QPS_ENABLE_RESET 16'h0000

// ----------------------------------------
// register selects, one per command/query
// ----------------------------------------
`define QPS_SEL_W 4
`define QPS_SEL_Q_COND 4'h0
`define QPS_SEL_Q_EVENT 4'h1
`define QPS_SEL_Q_RISE 4'h2
`define QPS_SEL_Q_FALL 4'h3
`define QPS_SEL_Q_ENABLE 4'h4
`define QPS_SEL_P_COND 4'h8
`define QPS_SEL_P_EVENT 4'h9
`define QPS_SEL_P_RISE 4'ha
`define QPS_SEL_P_FALL 4'hb
`define QPS_SEL_P_ENABLE 4'hc

`endif

// *** hw/qps_group.v ***
// one status group: condition, transition filters, event latch, enable, summary
// assumes cond_in is already synchronous to sys_clk
`include "qps_defines.vh"

module qps_group #(
   parameter WIDTH = 16
) (
   // clock and control
   input wire sys_clk,
   input wire reset,
   input wire clk_en,
   // live condition
   input wire [WIDTH-1:0] cond_in,
   // register writes
   input wire rise_wr,
   input wire fall_wr,
   input wire enable_wr,
   input wire [WIDTH-1:0] wr_data,
   // destructive event read
   input wire event_rd,
   // state
   output reg [WIDTH-1:0] cond,
   output reg [WIDTH-1:0] rise_filter,
   output reg [WIDTH-1:0] fall_filter,
   output reg [WIDTH-1:0] event_bits,
   output reg [WIDTH-1:0] enable_mask,
   output wire summary
);

   wire [WIDTH-1:0] hits;
   reg [WIDTH-1:0] next_event;

   // ----------------------------------------
   // transition detect
   // ----------------------------------------
   assign hits = (~cond & cond_in & rise_filter) | (cond & ~cond_in & fall_filter);

   // set wins over the read-clear so no transition is lost
   always @* begin
      next_event = event_rd ? {WIDTH{1'b0}} : event_bits;
      next_event = next_event | hits;
   end

   always @(posedge sys_clk) begin
      if (reset) begin
         cond <= {WIDTH{1'b0}};
         rise_filter <= `QPS_RISE_RESET;
         fall_filter <= `QPS_FALL_RESET;
         event_bits <= `QPS_EVENT_RESET;
         enable_mask <= `QPS_ENABLE_RESET;
      end else if (clk_en) begin
         cond <= cond_in;
         event_bits <= next_event;
         if (rise_wr) begin
            rise_filter <= wr_data;
         end
         if (fall_wr) begin
            fall_filter <= wr_data;
         end
         if (enable_wr) begin
            enable_mask <= wr_data;
         end
      end
   end

   // ----------------------------------------
   // summary
   // ----------------------------------------
   assign summary = |(event_bits & enable_mask);

endmodule

// *** tb/qps_props.sv ***
// checker for qps_top: command answers, guard latch, summary timing
// assumes clk_en stays high wherever a latency is timed
module qps_props #(
   parameter WIDTH = 16
) (
   // clock and control
   input wire sys_clk,
   input wire reset,
   input wire clk_en,
   // guard pins
   input wire guard_trip,
   input wire guard_clear,
   // command port
   input wire cmd_wr,
   input wire cmd_rd,
   input wire [3:0] cmd_sel,
   input wire [WIDTH-1:0] cmd_wdata,
   input wire [WIDTH-1:0] cmd_rdata,
   input wire cmd_rvalid,
   // summaries
   input wire status_byte_ques,
   input wire guard_tripped
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_read_answered: assert property (cmd_rd && clk_en |=> cmd_rvalid)
      else $error("read without answer");
   a_rdata_holds: assert property (!cmd_rvalid |-> $stable(cmd_rdata))
      else $error("read data moved without read");
   a_pcond_upper_zero: assert property (
      cmd_rvalid && $past(cmd_sel) == 4'h8 |-> cmd_rdata[WIDTH-1:4] == 0)
      else $error("power condition upper bits set");
   a_mask_read_back: assert property (
      cmd_wr && cmd_sel == 4'hc ##1 cmd_rd && !cmd_wr && cmd_sel == 4'hc
      |=> cmd_rdata == $past(cmd_wdata, 2))
      else $error("enable mask read back wrong");
   a_guard_holds: assert property (guard_tripped && !guard_clear |=> guard_tripped)
      else $error("guard bit dropped without clear");
   a_guard_rise_cause: assert property (
      $rose(guard_tripped) |-> $past(guard_trip, 3))
      else $error("guard bit rose without trip");
   a_guard_fall_cause: assert property ($fell(guard_tripped) |-> $past(guard_clear))
      else $error("guard bit fell without clear");
   // summary drops two edges after the event read or the enable write
   a_status_fall_cause: assert property (
      $fell(status_byte_ques) |-> $past(cmd_rd && cmd_sel == 4'h1 || cmd_wr && cmd_sel == 4'h4, 2))
      else $error("status summary fell without cause");
   c_guard_trip: cover property ($rose(guard_tripped));
   c_status_up: cover property ($rose(status_byte_ques));
   c_event_read: cover property (cmd_rvalid && $past(cmd_sel) == 4'h9 && cmd_rdata != 0);
endmodule

bind qps_top qps_props #(.WIDTH(WIDTH)) qps_props_inst (
   .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .guard_trip(guard_trip),
   .guard_clear(guard_clear), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_sel(cmd_sel),
   .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
   .status_byte_ques(status_byte_ques), .guard_tripped(guard_tripped));

// *** tb/testbench.sv ***
// self-checking bench for qps_top through its command port and its status_byte_ques and guard_tripped outputs
// assumes every task is entered at a falling edge
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, reset = 1, clk_en = 1, guard_clear = 0, freq_summary = 0;
   logic cmd_wr = 0, cmd_rd = 0;
   logic [3:0] pins = 0, cmd_sel = 0;
   logic [15:0] ques_other = 0, cmd_wdata = 0;
   wire [15:0] cmd_rdata;
   wire cmd_rvalid, status_byte_ques, guard_tripped;
   int error_cnt = 0, check_count = 0;

   always #4 sys_clk = ~sys_clk;

   qps_top qps_top_inst (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
      .guard_trip(pins[0]), .unleveled(pins[1]), .iq_overdrive(pins[2]),
      .heater_fault(pins[3]), .freq_summary(freq_summary), .guard_clear(guard_clear),
      .ques_other_cond(ques_other), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_sel(cmd_sel),
      .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
      .status_byte_ques(status_byte_ques), .guard_tripped(guard_tripped));

   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask
   task idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task wr(input logic [3:0] sel, input logic [15:0] d);
      cmd_wr = 1;
      cmd_sel = sel;
      cmd_wdata = d;
      idle(1);
      cmd_wr = 0;
      idle(1);
   endtask
   // rvalid stands one cycle, so it is looked at the falling edge after the take
   task rd(input logic [3:0] sel, input logic [15:0] exp);
      cmd_rd = 1;
      cmd_sel = sel;
      idle(1);
      cmd_rd = 0;
      chk(cmd_rvalid === 1'b1 ? cmd_rdata : 16'hxxxx, exp);
      idle(1);
   endtask
   // write then read with no gap between them
   task wr_rd(input logic [3:0] sel, input logic [15:0] d);
      cmd_wr = 1;
      cmd_sel = sel;
      cmd_wdata = d;
      idle(1);
      cmd_wr = 0;
      rd(sel, d);
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      idle(6);
      reset = 0;
      rd(4'ha, 16'hffff);
      rd(4'hb, 16'h0000);
      rd(4'hc, 16'h0000);
      rd(4'h2, 16'hffff);
      rd(4'h9, 16'h0000);
      wr(4'h8, 16'hffff);
      rd(4'h8, 16'h0000);
      rd(4'h5, 16'h0000);
      for (int i = 1; i < 4; i++) begin
         pins[i] = 1'b1;
         idle(6);
         rd(4'h8, 16'h1 << i);
         rd(4'h9, 16'h1 << i);
         rd(4'h9, 16'h0);
         pins[i] = 1'b0;
         idle(6);
         rd(4'h9, 16'h0);
      end
      wr(4'hb, 16'h0002);
      wr(4'ha, 16'h0000);
      pins[1] = 1'b1;
      idle(6);
      rd(4'h9, 16'h0000);
      pins[1] = 1'b0;
      idle(6);
      rd(4'h9, 16'h0002);
      wr(4'ha, 16'hffff);
      wr(4'hb, 16'h0000);
      // bit 5 of the other inputs stays low so only the frequency summary can set it
      ques_other = 16'h0208;
      freq_summary = 1;
      idle(6);
      rd(4'h0, 16'h0220);
      rd(4'h1, 16'h0220);
      ques_other = 16'h0000;
      freq_summary = 0;
      idle(6);
      rd(4'h1, 16'h0000);
      wr(4'h3, 16'h0200);
      wr(4'h2, 16'h0000);
      rd(4'h3, 16'h0200);
      ques_other = 16'h0220;
      idle(6);
      rd(4'h0, 16'h0200);
      rd(4'h1, 16'h0000);
      ques_other = 16'h0000;
      idle(6);
      rd(4'h1, 16'h0200);
      wr(4'h2, 16'hffff);
      wr(4'h3, 16'h0000);
      wr_rd(4'hc, 16'h000c);
      wr_rd(4'h4, 16'h0208);
      pins[3] = 1'b1;
      idle(10);
      chk({15'h0, status_byte_ques}, 16'h1);
      rd(4'h0, 16'h0008);
      rd(4'h9, 16'h0008);
      idle(4);
      chk({15'h0, status_byte_ques}, 16'h1);
      rd(4'h1, 16'h0008);
      idle(3);
      chk({15'h0, status_byte_ques}, 16'h0);
      pins[3] = 1'b0;
      pins[0] = 1'b1;
      idle(6);
      chk({15'h0, guard_tripped}, 16'h1);
      pins[0] = 1'b0;
      idle(6);
      rd(4'h8, 16'h0001);
      guard_clear = 1;
      idle(1);
      guard_clear = 0;
      idle(2);
      chk({15'h0, guard_tripped}, 16'h0);
      rd(4'h8, 16'h0000);
      // frozen clock enable: a pin change must not reach the condition word
      clk_en = 0;
      pins[1] = 1'b1;
      idle(6);
      clk_en = 1;
      rd(4'h8, 16'h0000);
      idle(6);
      rd(4'h8, 16'h0002);
      rd(4'h9, 16'h0003);
      pins[1] = 1'b0;
      idle(6);
      wrap_up();
   end
endmodule
